// *** drcm_top.sv ***
/*
  dram / synchronous dram row-column address multiplexer with burst
  same-row detection and a small access sequencer.
  assumes a same-clock access requester and a plain register port.

// What this block does
// - shift row address down by selected amount
// - select field picks compared row bits
// - precharge indication with sdram bit and space
// - code x00: 8-bit shift, compare from A8/A9
// - code x01: 9-bit shift, compare from A9/A10
// - code x10: 10-bit shift, compare from A10/A11
// - code x11: 11-bit shift, compare from A11/A12
// - 16-bit space compares one bit higher
// - precharge indication on column A15 down
// - burst disabled forces full access always
*/
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module drcm_top (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic acc_valid_in,
  input wire logic [23:0] acc_addr_in,
  output logic acc_ready_out,
  output logic acc_done_out,
  output logic [15:0] mem_addr_out,
  output logic row_strobe_out,
  output logic col_strobe_out,
  output logic close_strobe_out
);

  // ****************************************
  // declarations
  // ****************************************
  drcm_addr_if ai ();

  drcm_pkg::drcm_state_t state_r;
  drcm_pkg::drcm_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [23:0] addr_r;
  logic [23:0] open_addr_r;
  logic row_open_r;
  logic reopen_r;
  logic last_hit_r;
  logic [15:0] hit_cnt_r;
  logic [15:0] miss_cnt_r;
  logic [31:0] rdata_r;
  logic [15:0] mem_addr_r;
  logic row_strobe_r;
  logic col_strobe_r;
  logic close_strobe_r;
  logic done_r;
  logic burst_access_en;
  logic sdram_space_en;
  logic space_16bit;
  logic [2:0] mux_sel;
  logic mux_sel_interface_bit;
  logic mux_sel_shift_hi;
  logic mux_sel_shift_lo;
  logic accept;
  logic burst_hit;
  logic ctrl_wr;
  logic auto_close;

  // ****************************************
  // control field decode
  // ****************************************
  assign burst_access_en = ctrl_r[drcm_pkg::CTRL_BURST_BIT];
  assign sdram_space_en = ctrl_r[drcm_pkg::CTRL_SDR_BIT];
  assign space_16bit = ctrl_r[drcm_pkg::CTRL_W16_BIT];
  assign mux_sel = ctrl_r[drcm_pkg::CTRL_SEL_LSB +: drcm_pkg::CTRL_SEL_W];
  assign mux_sel_interface_bit = mux_sel[2];
  assign mux_sel_shift_hi = mux_sel[1];
  assign mux_sel_shift_lo = mux_sel[0];

  // ****************************************
  // helpers
  // ****************************************
  assign ai.mux_sel = {mux_sel_interface_bit, mux_sel_shift_hi, mux_sel_shift_lo};
  assign ai.space_16bit = space_16bit;
  assign ai.sdram_space_en = sdram_space_en;
  // column carries the close indication only when no burst keeps the row
  assign ai.pc_flag = ~burst_access_en;
  // compare against the incoming address while idle, held address after
  assign ai.addr = (state_r == drcm_pkg::DRCM_IDLE) ? acc_addr_in : addr_r;
  assign ai.open_addr = open_addr_r;

  drcm_addr_mux u_mux (
    .a(ai.mux)
  );

  drcm_row_cmp u_cmp (
    .a(ai.cmp)
  );

  // ****************************************
  // sequencer
  // ****************************************
  assign acc_ready_out = (state_r == drcm_pkg::DRCM_IDLE);
  assign accept = acc_valid_in & acc_ready_out;
  // a hit only counts while burst access is on and a row is open
  assign burst_hit = burst_access_en & row_open_r & ai.row_hit;
  assign ctrl_wr = reg_wr_in && (reg_addr_in == drcm_pkg::CTRL_OFS);
  // sdram with indication closes the row on the column cycle of a full access
  assign auto_close = mux_sel_interface_bit & sdram_space_en;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      drcm_pkg::DRCM_IDLE: begin
        if (accept) begin
          if (burst_hit) begin
            state_nxt = drcm_pkg::DRCM_COLUMN;
          end else if (row_open_r) begin
            state_nxt = drcm_pkg::DRCM_CLOSE;
          end else begin
            state_nxt = drcm_pkg::DRCM_OPEN;
          end
        end
      end
      drcm_pkg::DRCM_CLOSE: begin
        state_nxt = reopen_r ? drcm_pkg::DRCM_OPEN : drcm_pkg::DRCM_IDLE;
      end
      drcm_pkg::DRCM_OPEN: begin
        state_nxt = drcm_pkg::DRCM_COLUMN;
      end
      drcm_pkg::DRCM_COLUMN: begin
        if (burst_access_en || auto_close) begin
          state_nxt = drcm_pkg::DRCM_IDLE;
        end else begin
          state_nxt = drcm_pkg::DRCM_CLOSE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= drcm_pkg::DRCM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_r <= 24'h000000;
    end else if (accept) begin
      addr_r <= acc_addr_in;
    end
  end

  // close from idle reopens; close after a full access does not
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reopen_r <= 1'b0;
    end else if (accept) begin
      reopen_r <= 1'b1;
    end else if (state_r == drcm_pkg::DRCM_COLUMN) begin
      reopen_r <= 1'b0;
    end
  end

  // ****************************************
  // open row tracking
  // ****************************************
  // a config write drops the row: old compare range no longer valid
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      row_open_r <= 1'b0;
    end else if (state_r == drcm_pkg::DRCM_OPEN) begin
      row_open_r <= 1'b1;
    end else if (state_r == drcm_pkg::DRCM_CLOSE) begin
      row_open_r <= 1'b0;
    end else if (state_r == drcm_pkg::DRCM_COLUMN && !burst_access_en) begin
      row_open_r <= 1'b0;
    end else if (ctrl_wr) begin
      row_open_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      open_addr_r <= 24'h000000;
    end else if (state_r == drcm_pkg::DRCM_OPEN) begin
      open_addr_r <= addr_r;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_hit_r <= 1'b0;
    end else if (accept) begin
      last_hit_r <= burst_hit;
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_addr_r <= 16'h0000;
    end else if (state_r == drcm_pkg::DRCM_OPEN) begin
      mem_addr_r <= ai.row_addr;
    end else if (state_r == drcm_pkg::DRCM_COLUMN) begin
      mem_addr_r <= ai.col_addr;
    end
  end

  // strobes registered beside the address: pins and strobe move on one edge
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      row_strobe_r <= 1'b0;
    end else begin
      row_strobe_r <= (state_r == drcm_pkg::DRCM_OPEN);
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      col_strobe_r <= 1'b0;
    end else begin
      col_strobe_r <= (state_r == drcm_pkg::DRCM_COLUMN);
    end
  end

  // no close pulse after a full access for sdram with indication: the column already closes
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      close_strobe_r <= 1'b0;
    end else begin
      close_strobe_r <= (state_r == drcm_pkg::DRCM_CLOSE);
    end
  end

  // done rides with the column, not with ready, so a close may still follow
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == drcm_pkg::DRCM_COLUMN);
    end
  end

  assign mem_addr_out = mem_addr_r;
  assign row_strobe_out = row_strobe_r;
  assign col_strobe_out = col_strobe_r;
  assign close_strobe_out = close_strobe_r;
  assign acc_done_out = done_r;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= drcm_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= reg_wdata_in[7:0];
    end
  end

  // counters saturate; a write to either clears it, a count the same cycle wins
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hit_cnt_r <= drcm_pkg::CNT_RST;
    end else if (accept && burst_hit) begin
      hit_cnt_r <= (&hit_cnt_r) ? hit_cnt_r : hit_cnt_r + 16'h0001;
    end else if (reg_wr_in && reg_addr_in == drcm_pkg::HIT_OFS) begin
      hit_cnt_r <= drcm_pkg::CNT_RST;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      miss_cnt_r <= drcm_pkg::CNT_RST;
    end else if (accept && !burst_hit) begin
      miss_cnt_r <= (&miss_cnt_r) ? miss_cnt_r : miss_cnt_r + 16'h0001;
    end else if (reg_wr_in && reg_addr_in == drcm_pkg::MISS_OFS) begin
      miss_cnt_r <= drcm_pkg::CNT_RST;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= 32'h00000000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        drcm_pkg::CTRL_OFS: rdata_r <= {24'h000000, ctrl_r};
        drcm_pkg::STAT_OFS: rdata_r <= {open_addr_r, 5'h00, last_hit_r,
                                        ~acc_ready_out, row_open_r};
        drcm_pkg::HIT_OFS: rdata_r <= {16'h0000, hit_cnt_r};
        drcm_pkg::MISS_OFS: rdata_r <= {16'h0000, miss_cnt_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule

// *** drcm_pkg.sv ***
/*
  shared constants, types and decode helpers for the dram row/column
  address multiplexer. assumes a 24-bit system address and 16 memory
  address pins.
*/
package drcm_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int MEM_A_W = 16;
  localparam int REG_A_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] HIT_OFS = 8'h08;
  localparam logic [7:0] MISS_OFS = 8'h0C;

  // control fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_W = 3;
  localparam int CTRL_W16_BIT = 4;
  localparam int CTRL_SDR_BIT = 6;
  localparam int CTRL_BURST_BIT = 7;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // status fields
  localparam int STAT_OPEN_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_HIT_BIT = 2;
  localparam int STAT_ROW_LSB = 8;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ****************************************
  // address multiplex constants
  // ****************************************
  localparam logic [4:0] ROW_SHIFT_BASE = 5'h08;
  localparam logic [4:0] PSEL_BASE = 5'h09;
  localparam int PSEL_TOP = 15;

  typedef enum {
    DRCM_IDLE,
    DRCM_CLOSE,
    DRCM_OPEN,
    DRCM_COLUMN
  } drcm_state_t;

  // true when bit index idx lies at or above the low bound lo
  function automatic logic drcm_at_or_above(input int idx, input logic [4:0] lo);
    drcm_at_or_above = (idx >= int'(lo));
  endfunction

endpackage

// *** drcm_addr_if.sv ***
/*
  carrier between the sequencer and its address helpers.
  assumes one clock domain; all signals combinational here.
*/
`timescale 1ns/10ps
interface drcm_addr_if;
  logic [2:0] mux_sel;
  logic space_16bit;
  logic sdram_space_en;
  logic pc_flag;
  logic [23:0] addr;
  logic [23:0] open_addr;
  logic [15:0] row_addr;
  logic [15:0] col_addr;
  logic row_hit;

  modport seq (output mux_sel, space_16bit, sdram_space_en, pc_flag, addr, open_addr,
               input row_addr, col_addr, row_hit);
  modport mux (input mux_sel, sdram_space_en, pc_flag, addr,
               output row_addr, col_addr);
  modport cmp (input mux_sel, space_16bit, addr, open_addr,
               output row_hit);
endinterface

// *** drcm_addr_mux.sv ***
/*
  row and column address formation for the memory pins.
  assumes the sequencer holds addr steady while it is used.
*/
`timescale 1ns/10ps
module drcm_addr_mux (
  drcm_addr_if.mux a
);

  logic [4:0] shift;
  logic [4:0] psel_lo;
  logic psel_on;
  logic [23:0] shifted;

  // ****************************************
  // row address
  // ****************************************
  assign shift = drcm_pkg::ROW_SHIFT_BASE + {3'h0, a.mux_sel[1:0]};
  assign shifted = a.addr >> shift;
  assign a.row_addr = shifted[15:0];

  // ****************************************
  // column address
  // ****************************************
  // indication only when both the interface bit and sdram space agree
  assign psel_on = a.mux_sel[2] & a.sdram_space_en;
  assign psel_lo = drcm_pkg::PSEL_BASE + {3'h0, a.mux_sel[1:0]};

  genvar i;
  generate
    for (i = 0; i < drcm_pkg::MEM_A_W; i++) begin : g_col
      if (i <= drcm_pkg::PSEL_TOP) begin : g_psel
        assign a.col_addr[i] = (psel_on && drcm_pkg::drcm_at_or_above(i, psel_lo)) ?
                               a.pc_flag : a.addr[i];
      end else begin : g_plain
        assign a.col_addr[i] = a.addr[i];
      end
    end
  endgenerate

endmodule

// *** drcm_row_cmp.sv ***
/*
  same-row detection for burst accesses.
  assumes open_addr holds the address that opened the current row.
*/
`timescale 1ns/10ps
module drcm_row_cmp (
  drcm_addr_if.cmp a
);

  logic [4:0] cmp_lo;
  logic [23:0] diff;

  // ****************************************
  // compare range
  // ****************************************
  // wide space starts one bit higher for the same shift
  assign cmp_lo = drcm_pkg::ROW_SHIFT_BASE + {3'h0, a.mux_sel[1:0]}
                  + {4'h0, a.space_16bit};

  genvar i;
  generate
    for (i = 0; i < drcm_pkg::ADDR_W; i++) begin : g_diff
      assign diff[i] = drcm_pkg::drcm_at_or_above(i, cmp_lo)
                       & (a.addr[i] ^ a.open_addr[i]);
    end
  endgenerate

  assign a.row_hit = ~|diff;

endmodule

// *** drcm_mem_model.sv ***
/*
  external memory stand-in: tracks whether a row is open and counts
  column commands issued with no activated row.
  assumes one-cycle strobes on mclk_in.
*/
`timescale 1ns/10ps
module drcm_mem_model (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic row_strobe_in,
  input wire logic col_strobe_in,
  input wire logic close_strobe_in,
  output logic [7:0] bad_col_out
);
  // ****************
  // open row
  // ****************
  logic open_r;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      open_r <= 1'b0;
      bad_col_out <= 8'h00;
    end else begin
      if (close_strobe_in) open_r <= 1'b0;
      if (row_strobe_in) open_r <= 1'b1;
      // a real part ignores such a column; we count it instead
      if (col_strobe_in && !open_r) bad_col_out <= bad_col_out + 8'h01;
    end
  end
endmodule

// *** drcm_top_chk.sv ***
/*
  concurrent checks on the ports of drcm_top.
  assumes control is written only while the sequencer is idle.
*/
`timescale 1ns/10ps
module drcm_top_chk (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic acc_valid_in,
  input wire logic [23:0] acc_addr_in,
  input wire logic acc_ready_out,
  input wire logic acc_done_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic row_strobe_out,
  input wire logic col_strobe_out,
  input wire logic close_strobe_out
);
  // ****************
  // shadow state
  // ****************
  logic [7:0] ctrl_r;
  logic [23:0] acc_r;
  logic [23:0] open_a_r;
  logic open_r;
  logic acc_w;
  logic match_w;
  logic hit_w;
  logic [4:0] lo_w;
  logic [15:0] col_w;
  assign acc_w = acc_valid_in && acc_ready_out;
  assign lo_w = 5'h08 + 5'(ctrl_r[1:0]) + 5'(ctrl_r[4]);
  assign match_w = ((acc_addr_in ^ open_a_r) >> lo_w) == 24'h000000;
  assign hit_w = ctrl_r[7] && open_r && match_w;
  always_comb begin
    col_w = acc_r[15:0];
    for (int i = 9; i < 16; i++) begin
      if (ctrl_r[2] && ctrl_r[6] && i >= 9 + int'(ctrl_r[1:0])) col_w[i] = !ctrl_r[7];
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= 8'h00;
      acc_r <= 24'h000000;
      open_a_r <= 24'h000000;
      open_r <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'h00) ctrl_r <= reg_wdata_in[7:0];
      if (acc_w) acc_r <= acc_addr_in;
      if (close_strobe_out || (reg_wr_in && reg_addr_in == 8'h00)) open_r <= 1'b0;
      if (row_strobe_out) open_r <= 1'b1;
      if (row_strobe_out) open_a_r <= acc_r;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero outside read answer");
  AST_UNMAPPED: assert property (reg_rd_in && reg_addr_in > 8'h0C |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_ROW: assert property (row_strobe_out |-> mem_addr_out == 16'(acc_r >> (5'h08 + 5'(ctrl_r[1:0]))))
    else $error("row address shift wrong");
  AST_COL: assert property (col_strobe_out |-> mem_addr_out == col_w)
    else $error("column address wrong");
  AST_HIT: assert property (acc_w && hit_w |=> !row_strobe_out ##1 acc_done_out)
    else $error("row hit not served from open row");
  AST_MISS: assert property (acc_w && ctrl_r[7] && open_r && !match_w |-> ##2 close_strobe_out ##1 row_strobe_out ##1 acc_done_out)
    else $error("row miss sequence wrong");
  AST_FULL: assert property (acc_w && !ctrl_r[7] |-> ##[2:3] row_strobe_out)
    else $error("full access without row activation");
  AST_ORDER: assert property (row_strobe_out |=> col_strobe_out && !row_strobe_out)
    else $error("column does not follow row");
  COV_HIT: cover property (acc_w && hit_w);
  COV_MISS: cover property (acc_w && ctrl_r[7] && open_r && !match_w);
  COV_PSEL: cover property (col_strobe_out && ctrl_r[2] && ctrl_r[6] && !ctrl_r[7]);
endmodule

bind drcm_top drcm_top_chk i_drcm_top_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .acc_valid_in(acc_valid_in),
  .acc_addr_in(acc_addr_in), .acc_ready_out(acc_ready_out), .acc_done_out(acc_done_out),
  .mem_addr_out(mem_addr_out), .row_strobe_out(row_strobe_out),
  .col_strobe_out(col_strobe_out), .close_strobe_out(close_strobe_out));

// *** drcm_top_tb.sv ***
/*
  self-checking bench for drcm_top: every select code, both space widths.
  assumes the register and access ports of drcm_top and a 25 MHz clock.
*/
`timescale 1ns/10ps
module drcm_top_tb;
  // ****************
  // signals, notes
  // ****************
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic acc_valid_in = 1'b0;
  logic [23:0] acc_addr_in = 24'h0;
  logic [31:0] reg_rdata_out;
  logic acc_ready_out, acc_done_out, row_strobe_out, col_strobe_out, close_strobe_out;
  logic [15:0] mem_addr_out;
  logic [7:0] bad_col;
  int fail_count = 0;
  int compares = 0;
  int lat_cnt = 0;
  logic [31:0] rdq[$];
  logic [15:0] rowq[$];
  logic [18:0] colq[$];
  logic [18:0] cn;
  logic [31:0] rs = 32'h55;
  logic [7:0] ctrl = 8'h00;
  logic open_v = 1'b0;
  logic [23:0] open_a = 24'h0;
  logic rd_d = 1'b0;

  drcm_top i_drcm_top (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .acc_valid_in(acc_valid_in), .acc_addr_in(acc_addr_in),
    .acc_ready_out(acc_ready_out), .acc_done_out(acc_done_out), .mem_addr_out(mem_addr_out),
    .row_strobe_out(row_strobe_out), .col_strobe_out(col_strobe_out),
    .close_strobe_out(close_strobe_out));
  drcm_mem_model i_drcm_mem_model (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .row_strobe_in(row_strobe_out), .col_strobe_in(col_strobe_out),
    .close_strobe_in(close_strobe_out), .bad_col_out(bad_col));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    rdq.push_back(e);
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic setctl(input logic [7:0] c);
    wr(8'h00, {24'h0, c});
    ctrl = c;
    open_v = 1'b0;
  endtask
  // expected row, column and latency worked out before the request
  task automatic acc(input logic [23:0] a);
    logic [4:0] sh;
    logic hit;
    logic [15:0] col;
    int n;
    sh = 5'h08 + 5'(ctrl[1:0]);
    hit = ctrl[7] && open_v && ((a ^ open_a) >> (sh + 5'(ctrl[4]))) == 24'h0;
    col = a[15:0];
    for (int i = 9; i < 16; i++) begin
      if (ctrl[2] && ctrl[6] && i > int'(sh)) col[i] = !ctrl[7];
    end
    if (!hit) rowq.push_back(16'(a >> sh));
    colq.push_back({hit ? 3'h2 : open_v ? 3'h4 : 3'h3, col});
    if (!hit) open_a = a;
    open_v = ctrl[7];
    @(posedge mclk_in);
    acc_valid_in <= 1'b1;
    acc_addr_in <= a;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (acc_ready_out !== 1'b1 && n < 20);
    acc_valid_in <= 1'b0;
    while (acc_done_out !== 1'b1 && n < 40) begin
      @(posedge mclk_in);
      n++;
    end
    while (acc_ready_out !== 1'b1 && n < 60) begin
      @(posedge mclk_in);
      n++;
    end
    check("acc_wait", 32'h1, 32'(n < 60));
  endtask

  // ****************
  // monitor
  // ****************
  always @(posedge mclk_in) begin
    lat_cnt <= (acc_valid_in && acc_ready_out) ? 1 : lat_cnt + 1;
    rd_d <= reg_rd_in;
    if (rd_d) check("rdata", rdq.size() > 0 ? rdq.pop_front() : 32'hFFFFFFFF, reg_rdata_out);
    if (row_strobe_out) check("row", rowq.size() > 0 ? 32'(rowq.pop_front()) : 32'hFFFFFFFF, 32'(mem_addr_out));
    if (acc_done_out) begin
      cn = colq.size() > 0 ? colq.pop_front() : 19'h7FFFF;
      check("column", 32'(cn[15:0]), 32'(mem_addr_out));
      check("latency", 32'(cn[18:16]), 32'(lat_cnt));
    end
  end

  // ****************
  // clock, run
  // ****************
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    summarize();
  end
  initial begin
    logic [23:0] a;
    logic [4:0] lo;
    repeat (12) @(posedge mclk_in);
    resetn_in <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    for (int m = 0; m < 16; m++) begin
      setctl({1'b1, m[0] ^ m[3], 1'b0, m[3], 1'b0, m[2:0]});
      rs = xs(rs);
      a = rs[23:0];
      lo = 5'h08 + 5'(m[1:0]) + 5'(m[3]);
      acc(a);
      acc(a ^ (24'h1 << (lo - 5'h01)));
      rd(8'h04, {open_a, 5'h00, 3'h5});
      acc(a ^ (24'h1 << lo));
      setctl({1'b0, m[0] ^ m[3], 1'b0, m[3], 1'b0, m[2:0]});
      rd(8'h00, {24'h0, ctrl});
      acc(a ^ 24'h5A5A5A);
      if (!m[2]) acc(a ^ 24'h5A5A5A);
      $display("mode %0d done", m);
    end
    wr(8'h10, 32'hFF);
    rd(8'h00, {24'h0, ctrl});
    rd(8'h08, 32'h10);
    rd(8'h0C, 32'h38);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    repeat (3) @(posedge mclk_in);
    check("leftover", 32'h0, 32'(rowq.size() + colq.size() + rdq.size()));
    check("bad_col", 32'h0, 32'(bad_col));
    summarize();
  end
endmodule
